/* File: logic/position_window_switch.sv */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
// Position window output with APB register access
module position_window_switch (
   // Clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst_n,
   // APB slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [pos_window_pkg::ADDR_W-1:0]     paddr,
   input  wire logic [31:0]                           pwdata,
   input  wire logic [3:0]                            pstrb,
   output logic [31:0]                                prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   // Position sources
   input  wire logic signed [pos_window_pkg::POS_W-1:0] motorFeedbackPosition,
   input  wire logic signed [pos_window_pkg::POS_W-1:0] motorCommandedPosition,
   input  wire logic signed [pos_window_pkg::POS_W-1:0] masterFeedbackPosition,
   // Homing state
   input  wire logic                                  axisHomed,
   input  wire logic                                  homeDefineRequest,
   input  wire logic                                  masterPositionValid,
   // Window output
   output logic                                       windowActiveOutput
);

   logic [pos_window_pkg::CTRL_W-1:0]        ctrl_q;
   logic signed [pos_window_pkg::POS_W-1:0]  windowStartPosition_q;
   logic signed [pos_window_pkg::POS_W-1:0]  windowEndPosition_q;
   logic signed [pos_window_pkg::POS_W-1:0]  repeatSpan_q;
   logic signed [pos_window_pkg::POS_W-1:0]  prevPos_q;
   logic                                     prevValid_q;
   logic                                     dirPositive_q;
   logic                                     homedSeen_q;
   logic                                     firstSeen_q;
   logic                                     windowActive_q;
   logic                                     windowActive_d;
   logic [31:0]                              prdata_q;
   logic                                     pready_q;
   logic                                     pslverr_q;
   logic [$clog2(pos_window_pkg::UPDATE_CYCLES+1)-1:0] tickCnt_q;
   logic                                     tick;
   logic signed [pos_window_pkg::POS_W-1:0]  selPos;
   logic signed [pos_window_pkg::POS_W-1:0]  wrapPos;
   logic                                     windowEnable;
   logic [1:0]                               directionQualifier;
   logic [1:0]                               positionSelector;
   logic                                     repeatSpanEnable;
   logic                                     wrapCase;
   logic                                     armed;
   logic                                     dirOk;
   logic                                     inWindow;
   logic                                     seenNow;
   logic                                     setup;
   logic                                     wrAccess;
   logic                                     addrHit;
   logic [31:0]                              readMux;

   assign windowEnable       = ctrl_q[pos_window_pkg::CTRL_EN_BIT];
   assign directionQualifier = ctrl_q[pos_window_pkg::CTRL_DIR_LSB +: 2];
   assign positionSelector   = ctrl_q[pos_window_pkg::CTRL_SRC_LSB +: 2];
   assign repeatSpanEnable   = ctrl_q[pos_window_pkg::CTRL_SPAN_BIT];

   // Motion update enable from a divider; direction is sampled only at this rate
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         tickCnt_q <= '0;
      else if (tick)
         tickCnt_q <= '0;
      else
         tickCnt_q <= tickCnt_q + 1'b1;
   end
   assign tick = (tickCnt_q == ($bits(tickCnt_q))'(pos_window_pkg::UPDATE_CYCLES - 1));

   // Source selection
   always_comb
   begin
      case (positionSelector)
         pos_window_pkg::SRC_MOTOR_CMD: selPos = motorCommandedPosition;
         pos_window_pkg::SRC_MASTER_FB: selPos = masterFeedbackPosition;
         default:                       selPos = motorFeedbackPosition;
      endcase
   end

   span_wrap #(
      .WIDTH (pos_window_pkg::POS_W)
   ) u_wrap (
      .posIn      (selPos),
      .span       (repeatSpan_q),
      .spanEnable (repeatSpanEnable),
      .posOut     (wrapPos)
   );

   // Direction uses the raw position so a fold at the span edge is not seen as reversal
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         prevPos_q <= pos_window_pkg::POS_RESET;
         prevValid_q <= 1'b0;
         dirPositive_q <= 1'b1;
      end
      else if (tick)
      begin
         prevPos_q <= selPos;
         prevValid_q <= 1'b1;
         if (prevValid_q && selPos > prevPos_q)
            dirPositive_q <= 1'b1;
         else if (prevValid_q && selPos < prevPos_q)
            dirPositive_q <= 1'b0;
      end
   end

   // Homed is sticky; a master source also needs a live valid
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         homedSeen_q <= 1'b0;
      else if (axisHomed || homeDefineRequest)
         homedSeen_q <= 1'b1;
   end
   assign armed = windowEnable && homedSeen_q
                  && (positionSelector != pos_window_pkg::SRC_MASTER_FB || masterPositionValid);

   // Window evaluation
   assign wrapCase = repeatSpanEnable && (windowStartPosition_q > windowEndPosition_q);
   assign seenNow  = firstSeen_q || (wrapPos >= windowStartPosition_q);
   always_comb
   begin
      case (directionQualifier)
         pos_window_pkg::QUAL_PLUS:  dirOk = dirPositive_q;
         pos_window_pkg::QUAL_MINUS: dirOk = !dirPositive_q;
         default:                    dirOk = 1'b1;
      endcase
      if (wrapCase)
         inWindow = seenNow && (wrapPos >= windowStartPosition_q || wrapPos < windowEndPosition_q);
      else
         inWindow = (wrapPos >= windowStartPosition_q) && (wrapPos < windowEndPosition_q);
      windowActive_d = armed && dirOk && inWindow;
   end

   // First arrival at start in the wrapped case; rearmed when the window stops
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         firstSeen_q <= 1'b0;
      else if (!armed || !wrapCase)
         firstSeen_q <= 1'b0;
      else if (wrapPos >= windowStartPosition_q)
         firstSeen_q <= 1'b1;
   end

   // Output follows the window every clock, one cycle behind its inputs
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         windowActive_q <= 1'b0;
      else
         windowActive_q <= windowActive_d;
   end
   assign windowActiveOutput = windowActive_q;

   // APB: ready is raised in the first access cycle, so no wait states
   assign setup    = psel && !penable;
   assign wrAccess = psel && penable && pwrite && pready_q;
   always_comb
   begin
      addrHit = 1'b1;
      readMux = 32'h00000000;
      case (paddr)
         pos_window_pkg::OFF_CTRL:   readMux = {{(32-pos_window_pkg::CTRL_W){1'b0}}, ctrl_q};
         pos_window_pkg::OFF_START:  readMux = windowStartPosition_q;
         pos_window_pkg::OFF_END:    readMux = windowEndPosition_q;
         pos_window_pkg::OFF_SPAN:   readMux = repeatSpan_q;
         pos_window_pkg::OFF_STATUS:
         begin
            readMux[pos_window_pkg::STAT_ACTIVE_BIT] = windowActive_q;
            readMux[pos_window_pkg::STAT_DIR_BIT]    = dirPositive_q;
            readMux[pos_window_pkg::STAT_HOMED_BIT]  = homedSeen_q;
            readMux[pos_window_pkg::STAT_SEEN_BIT]   = firstSeen_q;
         end
         pos_window_pkg::OFF_POS:    readMux = wrapPos;
         default:                    addrHit = 1'b0;
      endcase
   end

   // Bus answer registers
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !addrHit;
         if (setup)
            prdata_q <= pwrite ? 32'h00000000 : readMux;
      end
   end
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // Byte-lane merge for writes
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = wd[8*i +: 8];
      return r;
   endfunction

   // Writable registers; status and position are read only
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ctrl_q <= pos_window_pkg::CTRL_RESET;
         windowStartPosition_q <= pos_window_pkg::POS_RESET;
         windowEndPosition_q <= pos_window_pkg::POS_RESET;
         repeatSpan_q <= pos_window_pkg::POS_RESET;
      end
      else if (wrAccess)
      begin
         case (paddr)
            pos_window_pkg::OFF_CTRL:
               if (pstrb[0])
                  ctrl_q <= pwdata[pos_window_pkg::CTRL_W-1:0];
            pos_window_pkg::OFF_START: windowStartPosition_q <= mergeBytes(windowStartPosition_q, pwdata, pstrb);
            pos_window_pkg::OFF_END:   windowEndPosition_q <= mergeBytes(windowEndPosition_q, pwdata, pstrb);
            pos_window_pkg::OFF_SPAN:  repeatSpan_q <= mergeBytes(repeatSpan_q, pwdata, pstrb);
            default:                   ;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_both_dirs: assert property (armed && directionQualifier == pos_window_pkg::QUAL_BOTH && inWindow
      |=> windowActiveOutput) else $error("window not active with qualifier both");
   a_plus_only: assert property (directionQualifier == pos_window_pkg::QUAL_PLUS && !dirPositive_q
      |=> !windowActiveOutput) else $error("plus window active in negative travel");
   a_minus_only: assert property (directionQualifier == pos_window_pkg::QUAL_MINUS && dirPositive_q
      |=> !windowActiveOutput) else $error("minus window active in positive travel");
   a_between_on: assert property (armed && dirOk && !wrapCase && wrapPos >= windowStartPosition_q
      && wrapPos < windowEndPosition_q |=> windowActiveOutput) else $error("inside window but inactive");
   a_start_reach: assert property (armed && dirOk && dirPositive_q && !wrapCase
      && $rose(wrapPos >= windowStartPosition_q) && wrapPos < windowEndPosition_q
      |=> windowActiveOutput) else $error("start reached but inactive");
   a_end_off: assert property (!wrapCase && wrapPos >= windowEndPosition_q
      |=> !windowActiveOutput) else $error("active at or past end");
   a_neg_travel: assert property (!wrapCase && !dirPositive_q && wrapPos < windowStartPosition_q
      |=> !windowActiveOutput) else $error("active past start in negative travel");
   a_wrap_inside: assert property (wrapCase && wrapPos < windowStartPosition_q
      && wrapPos >= windowEndPosition_q |=> !windowActiveOutput) else $error("active inside wrapped gap");
   a_wrap_outside: assert property (wrapCase && armed && dirOk && firstSeen_q
      && wrapPos < windowEndPosition_q |=> windowActiveOutput) else $error("wrapped window inactive");
   a_first_reach: assert property (wrapCase && !firstSeen_q && wrapPos < windowStartPosition_q
      |=> !windowActiveOutput) else $error("wrapped window on before start reached");
   a_lower_bound: assert property (!wrapCase && wrapPos < windowStartPosition_q
      |=> !windowActiveOutput) else $error("active below start");
   a_master_src: assert property (positionSelector == pos_window_pkg::SRC_MASTER_FB
      |-> selPos == masterFeedbackPosition) else $error("master source not selected");
   a_home_gate: assert property (!homedSeen_q && !axisHomed && !homeDefineRequest
      |=> !windowActiveOutput) else $error("active before homing");
   a_master_valid: assert property (positionSelector == pos_window_pkg::SRC_MASTER_FB && !masterPositionValid
      |=> !windowActiveOutput) else $error("master window active without valid");
   a_span_range: assert property (repeatSpanEnable && repeatSpan_q > 0
      |-> wrapPos >= 0 && wrapPos < repeatSpan_q) else $error("folded position out of span");
   a_dir_hold: assert property (tick && prevValid_q && selPos == prevPos_q
      |=> $stable(dirPositive_q)) else $error("direction changed without motion");
   a_dir_sign: assert property (tick && prevValid_q && selPos > prevPos_q
      |=> dirPositive_q) else $error("direction not positive on rising position");
   a_disable_off: assert property (!windowEnable |=> !windowActiveOutput)
      else $error("active while disabled");
   a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready after setup");

   // Falling travel, sticky homing and first-start rearm, then the bus answer shape
   a_dir_neg: assert property (tick && prevValid_q && selPos < prevPos_q
      |=> !dirPositive_q) else $error("direction not negative on falling position");
   a_seen_clear: assert property (!armed || !wrapCase
      |=> !firstSeen_q) else $error("first-start flag kept after window stopped");
   a_homed_sticky: assert property (homedSeen_q
      |=> homedSeen_q) else $error("homed flag lost without reset");
   a_err_ready: assert property (pslverr
      |-> pready) else $error("bus error without ready");
   a_ready_pulse: assert property (pready
      |=> !pready) else $error("ready held past one cycle");
   a_unmapped_err: assert property (psel && !penable && !addrHit
      |=> pslverr) else $error("unmapped address not refused");

   c_window_on: cover property (!windowActiveOutput ##1 windowActiveOutput);
   c_wrapped_on: cover property (wrapCase && windowActiveOutput);
   c_reverse: cover property (dirPositive_q ##1 !dirPositive_q);
   c_apb_write: cover property (wrAccess && paddr == pos_window_pkg::OFF_CTRL);
   c_bus_refused: cover property (pready && pslverr);

endmodule

/* File: logic/pos_window_pkg.sv */
package pos_window_pkg;

   localparam int POS_W = 32;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_START  = 8'h04;
   localparam logic [7:0] OFF_END    = 8'h08;
   localparam logic [7:0] OFF_SPAN   = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_POS    = 8'h14;

   // Control register layout
   localparam int CTRL_W        = 6;
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_DIR_LSB  = 1;
   localparam int CTRL_SRC_LSB  = 3;
   localparam int CTRL_SPAN_BIT = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam logic [POS_W-1:0]  POS_RESET  = 32'h00000000;

   // Status register layout
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_DIR_BIT    = 1;
   localparam int STAT_HOMED_BIT  = 2;
   localparam int STAT_SEEN_BIT   = 3;

   // Direction qualifier codes (code 3 behaves as Both)
   localparam logic [1:0] QUAL_BOTH  = 2'h0;
   localparam logic [1:0] QUAL_PLUS  = 2'h1;
   localparam logic [1:0] QUAL_MINUS = 2'h2;

   // Position selector codes (code 3 behaves as motor feedback)
   localparam logic [1:0] SRC_MOTOR_FB  = 2'h0;
   localparam logic [1:0] SRC_MOTOR_CMD = 2'h1;
   localparam logic [1:0] SRC_MASTER_FB = 2'h2;

   // Motion update rate
   localparam int CLK_PERIOD_NS    = 20;
   localparam int UPDATE_PERIOD_NS = 1000;
   localparam int UPDATE_CYCLES    = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: logic/span_wrap.sv */
`timescale 1ns/1ns
// Folds a position into [0, span) when the repeat span is in use
module span_wrap #(
   parameter int WIDTH = 32
) (
   // Position in
   input  wire logic signed [WIDTH-1:0] posIn,
   input  wire logic signed [WIDTH-1:0] span,
   input  wire logic                    spanEnable,
   // Folded position out
   output logic signed [WIDTH-1:0]      posOut
);

   logic signed [WIDTH-1:0] remainder;

   // Remainder keeps the dividend sign, so a negative one is lifted by one span
   always_comb
   begin
      remainder = '0;
      posOut = posIn;
      if (spanEnable && span > 0)
      begin
         remainder = posIn % span;
         posOut = (remainder < 0) ? remainder + span : remainder;
      end
   end

endmodule

/* File: tb/motion_source_model.sv */
`timescale 1ns/1ns
// Far-side motion source: position feeds and homing state for one axis
module motion_source_model (
   // Clock
   input  wire logic                                   clk_sys,
   // Position feeds
   output logic signed [pos_window_pkg::POS_W-1:0]      motorFeedbackPosition,
   output logic signed [pos_window_pkg::POS_W-1:0]      motorCommandedPosition,
   output logic signed [pos_window_pkg::POS_W-1:0]      masterFeedbackPosition,
   // Homing state
   output logic                                        axisHomed,
   output logic                                        homeDefineRequest,
   output logic                                        masterPositionValid
);
   int settle;

   // Quiet axis at power-up: not homed, master not defined
   initial
   begin
      settle = 0;
      motorFeedbackPosition = '0;
      motorCommandedPosition = '0;
      masterFeedbackPosition = '0;
      axisHomed = 1'b0;
      homeDefineRequest = 1'b0;
      masterPositionValid = 1'b0;
   end

   // Feeds sit at fixed offsets so a wrong selector shows; settle models a slow source
   task automatic place(input int p);
      repeat (settle + 1) @(posedge clk_sys);
      motorFeedbackPosition <= p;
      motorCommandedPosition <= p + 1000;
      masterFeedbackPosition <= p + 2000;
   endtask

   // One-cycle homing pulse, either homed report or home define
   task automatic home(input logic viaAxis);
      @(posedge clk_sys);
      axisHomed <= viaAxis;
      homeDefineRequest <= !viaAxis;
      @(posedge clk_sys);
      axisHomed <= 1'b0;
      homeDefineRequest <= 1'b0;
   endtask

   // Master position becomes valid once its home is defined
   task automatic setValid(input logic v);
      @(posedge clk_sys);
      masterPositionValid <= v;
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
// Window switch bench: APB master, motion source and a queue-ordered monitor
module tb_top;
   logic                                    clk_sys;
   logic                                    rst_n;
   logic                                    psel;
   logic                                    penable;
   logic                                    pwrite;
   logic [pos_window_pkg::ADDR_W-1:0]        paddr;
   logic [31:0]                             pwdata;
   logic [3:0]                              pstrb;
   logic [31:0]                             prdata;
   logic                                    pready;
   logic                                    pslverr;
   logic signed [pos_window_pkg::POS_W-1:0]  fbPos;
   logic signed [pos_window_pkg::POS_W-1:0]  cmdPos;
   logic signed [pos_window_pkg::POS_W-1:0]  mstPos;
   logic                                    homed;
   logic                                    homeDef;
   logic                                    mstValid;
   logic                                    windowActiveOutput;
   logic                                    sampleNow;
   logic [32:0]                             apbQ[$];
   logic                                    winQ[$];
   int                                      errCount;
   int                                      compares;
   int                                      seed;
   int                                      i;
   int                                      p;
   int                                      walkP[9] = '{99, 100, 199, 200, 250, 200, 199, 100, 99};
   logic                                    walkE[9] = '{0, 1, 1, 0, 0, 0, 1, 1, 0};

   position_window_switch position_window_switch_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .motorFeedbackPosition(fbPos), .motorCommandedPosition(cmdPos),
      .masterFeedbackPosition(mstPos), .axisHomed(homed), .homeDefineRequest(homeDef),
      .masterPositionValid(mstValid), .windowActiveOutput(windowActiveOutput));

   motion_source_model motion_source_model_inst (.clk_sys(clk_sys), .motorFeedbackPosition(fbPos),
      .motorCommandedPosition(cmdPos), .masterFeedbackPosition(mstPos), .axisHomed(homed),
      .homeDefineRequest(homeDef), .masterPositionValid(mstValid));

   // 50 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic printVerdict();
      if (errCount == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmpApb(input logic [32:0] e, input logic err, input logic [31:0] d);
      compares++;
      if ({err, d} !== e)
      begin
         errCount++;
         $display("BAD apb exp=%h seen=%h", e, {err, d});
      end
   endtask

   task automatic cmpWin(input logic e, input logic s);
      compares++;
      if (s !== e)
      begin
         errCount++;
         $display("BAD windowActiveOutput exp=%b seen=%b", e, s);
      end
   endtask

   // Each promised result is taken off its queue when the design shows it
   always @(posedge clk_sys)
   begin
      if (psel && penable && pready === 1'b1)
         cmpApb(apbQ.pop_front(), pslverr, prdata);
      if (sampleNow)
         cmpWin(winQ.pop_front(), windowActiveOutput);
   end

   // One APB transfer; request held until pready is sampled high, only the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [32:0] e);
      apbQ.push_back(e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF, 33'h000000000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000, 4'hF, {1'b0, e});
   endtask

   function automatic logic [31:0] ctl(logic en, logic [1:0] q, logic [1:0] s, logic sp);
      return {26'h0, sp, s, q, en};
   endfunction

   // Window off while bounds change, so no stale first-start state survives
   task automatic cfg(input int s, input int e, input int sp, input logic [31:0] c);
      wr(pos_window_pkg::OFF_CTRL, 32'h00000000);
      wr(pos_window_pkg::OFF_START, s);
      wr(pos_window_pkg::OFF_END, e);
      wr(pos_window_pkg::OFF_SPAN, sp);
      wr(pos_window_pkg::OFF_CTRL, c);
   endtask

   // Move the axis, let two direction updates pass, then promise the output level
   task automatic win(input int pos, input logic e);
      motion_source_model_inst.place(pos);
      repeat (110) @(posedge clk_sys);
      winQ.push_back(e);
      sampleNow <= 1'b1;
      @(posedge clk_sys);
      sampleNow <= 1'b0;
   endtask

   // Watchdog, well beyond the expected run of about 5600 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errCount++;
      printVerdict();
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, sampleNow} = '0;
      {errCount, compares} = '0;
      seed = 32'hA820;
      rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset values, refusals, strobes and read-only places
      rd(pos_window_pkg::OFF_CTRL, 32'h00000000);
      rd(pos_window_pkg::OFF_SPAN, 32'h00000000);
      apb(1'b0, 8'h18, 32'h00000000, 4'hF, 33'h100000000);
      apb(1'b1, 8'h18, 32'h12345678, 4'hF, 33'h100000000);
      apb(1'b1, pos_window_pkg::OFF_START, 32'hFFFFFFFF, 4'h1, 33'h000000000);
      rd(pos_window_pkg::OFF_START, 32'h000000FF);
      wr(pos_window_pkg::OFF_POS, 32'h00001234);
      rd(pos_window_pkg::OFF_POS, 32'h00000000);
      // Not homed yet, then home define arms the window
      cfg(100, 200, 0, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(150, 1'b0);
      motion_source_model_inst.home(1'b0);
      win(150, 1'b1);
      for (i = 0; i < 9; i++)
         win(walkP[i], walkE[i]);
      wr(pos_window_pkg::OFF_CTRL, ctl(1'b1, pos_window_pkg::QUAL_PLUS, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(150, 1'b1);
      win(120, 1'b0);
      wr(pos_window_pkg::OFF_CTRL, ctl(1'b1, pos_window_pkg::QUAL_MINUS, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(110, 1'b1);
      win(160, 1'b0);
      wr(pos_window_pkg::OFF_CTRL, ctl(1'b1, 2'h3, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(150, 1'b1);
      win(170, 1'b1);
      wr(pos_window_pkg::OFF_CTRL, 32'h00000000);
      win(140, 1'b0);
      // Source selection, master needs its valid
      wr(pos_window_pkg::OFF_CTRL, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_CMD, 1'b0));
      win(150, 1'b0);
      win(-900, 1'b1);
      wr(pos_window_pkg::OFF_CTRL, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MASTER_FB, 1'b0));
      win(-1850, 1'b0);
      motion_source_model_inst.setValid(1'b1);
      win(-1849, 1'b1);
      rd(pos_window_pkg::OFF_POS, 32'h00000097);
      // Both bounds negative, more negative one in start
      cfg(-300, -100, 0, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(-200, 1'b1);
      win(-100, 1'b0);
      win(-300, 1'b1);
      // Repeat span of 360
      cfg(90, 100, 360, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b1));
      win(455, 1'b1);
      win(460, 1'b0);
      rd(pos_window_pkg::OFF_POS, 32'h00000064);
      win(815, 1'b1);
      win(-270, 1'b1);
      // Wrapped window: start above end
      cfg(300, 60, 360, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b1));
      win(30, 1'b0);
      win(200, 1'b0);
      win(310, 1'b1);
      rd(pos_window_pkg::OFF_STATUS, 32'h0000000F);
      win(390, 1'b1);
      win(560, 1'b0);
      // Random positions against a plain window, with a slow source
      motion_source_model_inst.settle = 3;
      cfg(100, 200, 0, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      for (i = 0; i < 12; i++)
      begin
         p = {$random(seed)} % 300;
         win(p, p >= 100 && p < 200);
      end
      // Second reset clears homing; homed report re-arms
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(pos_window_pkg::OFF_CTRL, 32'h00000000);
      cfg(100, 200, 0, ctl(1'b1, pos_window_pkg::QUAL_BOTH, pos_window_pkg::SRC_MOTOR_FB, 1'b0));
      win(150, 1'b0);
      motion_source_model_inst.home(1'b1);
      win(160, 1'b1);
      repeat (3) @(posedge clk_sys);
      printVerdict();
   end
endmodule
